// ===== design/irel_pkg.sv
// Package: constants, register map and carrier types for the interrupt request enable logic
//
// Notes on behaviour
// - Basic timer overflow sets the basic timer request flag; it stays set while pending.
// - Basic timer request flag reads 0 when no request or while being serviced.
// - Serial transmission complete sets the serial request flag; it stays set while pending.
// - Serial request flag reads 0 when no request or while being serviced.
// - Software writing 0 to the serial request flag cancels a pending serial request.
// - Enable register index 2FH: bit3 basic timer, bit2 timer1, bit1 timer0, bit0 pin.
// - Pin enable 0 withholds pin service; pin request stays pending.
// - Pin enable 1 with global enable starts processing when the pin flag is set.
// - Timer 0 enable 0 withholds timer 0 service; its request stays pending.
// - Timer 0 enable 1 with global enable starts processing when timer 0 flag set.
// - Timer 1 enable 0 withholds timer 1 service; its request stays pending.
// - Timer 1 enable 1 with global enable starts processing when timer 1 flag set.
// - Basic timer enable 0 withholds its service; its request stays pending.
// - Basic timer enable 1 with global enable starts processing when its flag set.
// - Preparation cycle saves counter and status word and clears the accepted flag.
// - Processing begins only after the current instruction cycle completes.
// - Several enabled requests are serviced in descending priority; lower ones wait.
package irel_pkg;

    // ==========================================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IREL_IDX_ENABLE   = 6'h2F;
    localparam logic [5:0] IREL_IDX_BT_REQ   = 6'h3C;
    localparam logic [5:0] IREL_IDX_SER_REQ  = 6'h3D;
    localparam logic [5:0] IREL_IDX_STATUS   = 6'h30;
    localparam logic [5:0] IREL_IDX_MASK     = 6'h31;
    localparam logic [5:0] IREL_IDX_SERVICE  = 6'h32;

    // ==========================================================================
    // Enable register fields
    localparam int IREL_EN_EXT = 0;
    localparam int IREL_EN_TM0 = 1;
    localparam int IREL_EN_TM1 = 2;
    localparam int IREL_EN_BT  = 3;

    // Status / mask event fields
    localparam int IREL_EV_BT     = 0;
    localparam int IREL_EV_SER    = 1;
    localparam int IREL_EV_ACCEPT = 2;

    // Reset values
    localparam logic [3:0] IREL_RST_ENABLE = 4'h0;
    localparam logic       IREL_RST_FLAG   = 1'b0;
    localparam logic [2:0] IREL_RST_EVENTS = 3'h0;

    // Preparation cycle length in clocks
    localparam logic [1:0] IREL_PREP_CYCLES = 2'h1;

    // ==========================================================================
    // Source numbers, highest priority first
    typedef enum logic [2:0] {
        IREL_SRC_EXT  = 3'b000,
        IREL_SRC_TM0  = 3'b001,
        IREL_SRC_TM1  = 3'b010,
        IREL_SRC_BT   = 3'b011,
        IREL_SRC_SER  = 3'b100,
        IREL_SRC_NONE = 3'b111
    } irel_src_t;

    typedef enum logic [1:0] {
        IREL_ST_IDLE    = 2'b00,
        IREL_ST_PREP    = 2'b01,
        IREL_ST_SERVICE = 2'b10
    } irel_state_t;

    // Event sources and request flags kept elsewhere
    typedef struct packed {
        logic bt_overflow;
        logic serial_done;
        logic ext_request_flag;
        logic timer0_request_flag;
        logic timer1_request_flag;
        logic serial_enable;
    } irel_src_in_t;

    // CPU sequencer status
    typedef struct packed {
        logic global_interrupt_enable;
        logic instr_done;
        logic reti;
    } irel_cpu_in_t;

    // Preparation cycle outputs to the sequencer and flag owners
    typedef struct packed {
        logic      prep;
        irel_src_t vector;
        logic      clr_ext;
        logic      clr_tm0;
        logic      clr_tm1;
        logic      in_service;
    } irel_cpu_out_t;

endpackage

// ===== design/irel_top.sv
// Interrupt request flags, enables, acceptance sequencer and APB register slave
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module irel_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire irel_pkg::irel_src_in_t  src_in,
    input  wire irel_pkg::irel_cpu_in_t  cpu_in,
    output irel_pkg::irel_cpu_out_t      cpu_out,
    output logic                         irq
);
    import irel_pkg::*;

    // ==========================================================================
    // State
    logic [3:0]  enable_reg;
    logic        basic_timer_request_flag;
    logic        serial_request_flag;
    logic [2:0]  status;
    logic [2:0]  mask;
    irel_state_t state;
    irel_src_t   active_src;

    // ==========================================================================
    // Bus decode
    logic        setup;
    logic        wr_fire;
    logic [5:0]  idx;
    logic        aligned;
    logic        mapped;
    logic        bad_addr;

    assign setup    = psel & ~penable;
    assign wr_fire  = psel & penable & pready & pwrite;
    assign idx      = paddr[7:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign mapped   = (idx == IREL_IDX_ENABLE) || (idx == IREL_IDX_BT_REQ) ||
                      (idx == IREL_IDX_SER_REQ) || (idx == IREL_IDX_STATUS) ||
                      (idx == IREL_IDX_MASK) || (idx == IREL_IDX_SERVICE);
    assign bad_addr = ~(aligned & mapped);

    logic wr_enable;
    logic wr_bt;
    logic wr_ser;
    logic wr_status;
    logic wr_mask;

    assign wr_enable = wr_fire & ~bad_addr & (idx == IREL_IDX_ENABLE);
    assign wr_bt     = wr_fire & ~bad_addr & (idx == IREL_IDX_BT_REQ);
    assign wr_ser    = wr_fire & ~bad_addr & (idx == IREL_IDX_SER_REQ);
    assign wr_status = wr_fire & ~bad_addr & (idx == IREL_IDX_STATUS);
    assign wr_mask   = wr_fire & ~bad_addr & (idx == IREL_IDX_MASK);

    // ==========================================================================
    // Pending requests gated by enables and global enable
    logic [4:0] raw_req;
    logic [4:0] src_en;
    logic [4:0] pending;
    irel_src_t  winner;

    assign raw_req = {serial_request_flag, basic_timer_request_flag,
                      src_in.timer1_request_flag, src_in.timer0_request_flag,
                      src_in.ext_request_flag};
    assign src_en  = {src_in.serial_enable, enable_reg[IREL_EN_BT],
                      enable_reg[IREL_EN_TM1], enable_reg[IREL_EN_TM0],
                      enable_reg[IREL_EN_EXT]};

    // A disabled source keeps its flag; it is merely left out of the pick
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_gate
            assign pending[g] = raw_req[g] & src_en[g] &
                                cpu_in.global_interrupt_enable;
        end
    endgenerate

    // Lowest source number wins; the others stay pending untouched
    always_comb begin
        if (pending[0]) begin
            winner = IREL_SRC_EXT;
        end else if (pending[1]) begin
            winner = IREL_SRC_TM0;
        end else if (pending[2]) begin
            winner = IREL_SRC_TM1;
        end else if (pending[3]) begin
            winner = IREL_SRC_BT;
        end else if (pending[4]) begin
            winner = IREL_SRC_SER;
        end else begin
            winner = IREL_SRC_NONE;
        end
    end

    logic accept;
    // Only at an instruction boundary, so the running instruction completes first
    assign accept = (state == IREL_ST_IDLE) & cpu_in.instr_done &
                    (winner != IREL_SRC_NONE);

    // ==========================================================================
    // Acceptance sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= IREL_ST_IDLE;
            active_src <= IREL_SRC_NONE;
        end else begin
            case (state)
                IREL_ST_IDLE: begin
                    if (accept) begin
                        state      <= IREL_ST_PREP;
                        active_src <= winner;
                    end
                end
                IREL_ST_PREP: begin
                    state <= IREL_ST_SERVICE;
                end
                IREL_ST_SERVICE: begin
                    // No nesting: a new request waits until return
                    if (cpu_in.reti) begin
                        state      <= IREL_ST_IDLE;
                        active_src <= IREL_SRC_NONE;
                    end
                end
                default: begin
                    state      <= IREL_ST_IDLE;
                    active_src <= IREL_SRC_NONE;
                end
            endcase
        end
    end

    // Sequencer outputs, registered; prep lasts exactly the preparation cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_out <= '{prep: 1'b0, vector: IREL_SRC_NONE, clr_ext: 1'b0,
                         clr_tm0: 1'b0, clr_tm1: 1'b0, in_service: 1'b0};
        end else begin
            cpu_out.prep       <= accept;
            cpu_out.vector     <= accept ? winner : active_src;
            cpu_out.clr_ext    <= accept & (winner == IREL_SRC_EXT);
            cpu_out.clr_tm0    <= accept & (winner == IREL_SRC_TM0);
            cpu_out.clr_tm1    <= accept & (winner == IREL_SRC_TM1);
            cpu_out.in_service <= accept | ((state != IREL_ST_IDLE) &
                                            ~(state == IREL_ST_SERVICE & cpu_in.reti));
        end
    end

    logic clr_bt_accept;
    logic clr_ser_accept;

    assign clr_bt_accept  = accept & (winner == IREL_SRC_BT);
    assign clr_ser_accept = accept & (winner == IREL_SRC_SER);

    // ==========================================================================
    // Enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= IREL_RST_ENABLE;
        end else if (wr_enable) begin
            enable_reg <= pwdata[3:0];
        end
    end

    // Basic timer flag: overflow beats any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            basic_timer_request_flag <= IREL_RST_FLAG;
        end else if (src_in.bt_overflow) begin
            basic_timer_request_flag <= 1'b1;
        end else if (clr_bt_accept) begin
            basic_timer_request_flag <= 1'b0;
        end else if (wr_bt) begin
            basic_timer_request_flag <= pwdata[0];
        end
    end

    // Serial flag: completion wins, then a software write, so a forced request is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_request_flag <= IREL_RST_FLAG;
        end else if (src_in.serial_done) begin
            serial_request_flag <= 1'b1;
        end else if (wr_ser) begin
            serial_request_flag <= pwdata[0];
        end else if (clr_ser_accept) begin
            serial_request_flag <= 1'b0;
        end
    end

    // ==========================================================================
    // Sticky event status, write one to clear, set wins
    logic [2:0] events;
    logic [2:0] next_status;

    assign events      = {accept, src_in.serial_done, src_in.bt_overflow};
    assign next_status = events | (status & ~(wr_status ? pwdata[2:0] : 3'h0));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= IREL_RST_EVENTS;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= IREL_RST_EVENTS;
        end else if (wr_mask) begin
            mask <= pwdata[2:0];
        end
    end

    // Interrupt line follows the status that will be stored, so no extra lag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & (wr_mask ? pwdata[2:0] : mask));
        end
    end

    // ==========================================================================
    // APB answer: no wait state, data and error prepared in setup
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            IREL_IDX_ENABLE:  rd_mux = {28'h0000000, enable_reg};
            IREL_IDX_BT_REQ:  rd_mux = {31'h00000000, basic_timer_request_flag};
            IREL_IDX_SER_REQ: rd_mux = {31'h00000000, serial_request_flag};
            IREL_IDX_STATUS:  rd_mux = {29'h00000000, status};
            IREL_IDX_MASK:    rd_mux = {29'h00000000, mask};
            IREL_IDX_SERVICE: rd_mux = {27'h0000000, state == IREL_ST_SERVICE,
                                        state == IREL_ST_PREP, active_src};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & bad_addr;
            if (setup & ~pwrite & ~bad_addr) begin
                prdata <= rd_mux;
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================================
    // Checks
    sequence s_accept_then_prep;
        accept ##1 cpu_out.prep;
    endsequence

    property p_bt_set;
        @(posedge pclk) disable iff (!presetn)
        src_in.bt_overflow |=> basic_timer_request_flag;
    endproperty
    a_bt_set: assert property (p_bt_set) else $error("bt flag not set");

    property p_bt_clear_on_accept;
        @(posedge pclk) disable iff (!presetn)
        (clr_bt_accept && !src_in.bt_overflow) |=> !basic_timer_request_flag;
    endproperty
    a_bt_clear_on_accept: assert property (p_bt_clear_on_accept)
        else $error("bt flag kept after accept");

    property p_ser_set;
        @(posedge pclk) disable iff (!presetn)
        src_in.serial_done |=> serial_request_flag;
    endproperty
    a_ser_set: assert property (p_ser_set) else $error("serial flag not set");

    property p_ser_cancel;
        @(posedge pclk) disable iff (!presetn)
        (wr_ser && !pwdata[0] && !src_in.serial_done) |=> !serial_request_flag;
    endproperty
    a_ser_cancel: assert property (p_ser_cancel) else $error("serial cancel lost");

    property p_ser_force;
        @(posedge pclk) disable iff (!presetn)
        wr_ser && pwdata[0] |=> serial_request_flag;
    endproperty
    a_ser_force: assert property (p_ser_force) else $error("serial force lost");

    property p_no_accept_disabled;
        @(posedge pclk) disable iff (!presetn)
        (accept && winner == IREL_SRC_EXT) |-> enable_reg[IREL_EN_EXT];
    endproperty
    a_no_accept_disabled: assert property (p_no_accept_disabled)
        else $error("disabled pin accepted");

    property p_prep_pulse;
        @(posedge pclk) disable iff (!presetn)
        s_accept_then_prep |=> !cpu_out.prep && cpu_out.in_service;
    endproperty
    a_prep_pulse: assert property (p_prep_pulse) else $error("prep not one cycle");

    property p_accept_boundary;
        @(posedge pclk) disable iff (!presetn)
        $rose(cpu_out.prep) |-> $past(cpu_in.instr_done) && $past(cpu_in.global_interrupt_enable);
    endproperty
    a_accept_boundary: assert property (p_accept_boundary)
        else $error("accept off boundary");

    property p_priority;
        @(posedge pclk) disable iff (!presetn)
        (accept && pending[0]) |=> cpu_out.vector == IREL_SRC_EXT;
    endproperty
    a_priority: assert property (p_priority) else $error("priority wrong");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        (pready && (idx == IREL_IDX_SER_REQ || idx == IREL_IDX_BT_REQ)) |-> prdata[3:1] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    sequence s_serving;
        state == IREL_ST_SERVICE && !cpu_in.reti;
    endsequence

    property p_start_enabled;
        @(posedge pclk) disable iff (!presetn)
        (state == IREL_ST_IDLE && cpu_in.instr_done && cpu_in.global_interrupt_enable &&
         (|(raw_req & src_en))) |=> cpu_out.prep;
    endproperty
    a_start_enabled: assert property (p_start_enabled)
        else $error("enabled request not taken");

    property p_ser_clear_on_accept;
        @(posedge pclk) disable iff (!presetn)
        (clr_ser_accept && !src_in.serial_done && !wr_ser) |=> !serial_request_flag;
    endproperty
    a_ser_clear_on_accept: assert property (p_ser_clear_on_accept)
        else $error("serial flag kept after accept");

    property p_bt_held;
        @(posedge pclk) disable iff (!presetn)
        (basic_timer_request_flag && !enable_reg[IREL_EN_BT] && !wr_bt)
            |=> basic_timer_request_flag;
    endproperty
    a_bt_held: assert property (p_bt_held) else $error("bt request dropped");

    property p_tm0_withheld;
        @(posedge pclk) disable iff (!presetn)
        (cpu_out.prep && cpu_out.vector == IREL_SRC_TM0) |-> $past(enable_reg[IREL_EN_TM0]);
    endproperty
    a_tm0_withheld: assert property (p_tm0_withheld) else $error("tm0 taken disabled");

    property p_tm1_withheld;
        @(posedge pclk) disable iff (!presetn)
        (cpu_out.prep && cpu_out.vector == IREL_SRC_TM1) |-> $past(enable_reg[IREL_EN_TM1]);
    endproperty
    a_tm1_withheld: assert property (p_tm1_withheld) else $error("tm1 taken disabled");

    property p_bt_withheld;
        @(posedge pclk) disable iff (!presetn)
        (cpu_out.prep && cpu_out.vector == IREL_SRC_BT) |-> $past(enable_reg[IREL_EN_BT]);
    endproperty
    a_bt_withheld: assert property (p_bt_withheld) else $error("bt taken disabled");

    property p_no_nesting;
        @(posedge pclk) disable iff (!presetn)
        s_serving |=> !cpu_out.prep && cpu_out.in_service;
    endproperty
    a_no_nesting: assert property (p_no_nesting) else $error("nested accept");

    property p_clear_with_prep;
        @(posedge pclk) disable iff (!presetn)
        (cpu_out.prep && cpu_out.vector == IREL_SRC_EXT) |-> cpu_out.clr_ext;
    endproperty
    a_clear_with_prep: assert property (p_clear_with_prep)
        else $error("pin flag not cleared");

endmodule // irel_top

// ===== bench/irel_partner.sv
// Far-side model: CPU sequencer and the request flags held outside the block
`timescale 1ns/10ps
module irel_partner (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [2:0]              raise,
    input  wire logic                    gie,
    input  wire logic                    slow,
    input  wire irel_pkg::irel_cpu_out_t cpu_out,
    output logic      [2:0]              flags,
    output irel_pkg::irel_cpu_in_t       cpu_in
);
    import irel_pkg::*;
    logic [1:0] phase;
    logic [3:0] cnt;
    logic       busy;
    logic       reti;
    // ==========================================================================
    // Instruction cycle every four clocks; service ends after a short or long routine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            cnt   <= 4'h0;
            busy  <= 1'b0;
            reti  <= 1'b0;
            flags <= 3'h0;
        end else begin
            phase <= phase + 2'h1;
            reti  <= 1'b0;
            // Raise wins nothing here: a clear pulse always drops the flag
            flags <= (flags | raise) & ~{cpu_out.clr_ext, cpu_out.clr_tm0, cpu_out.clr_tm1};
            if (cpu_out.prep) begin
                busy <= 1'b1;
                cnt  <= slow ? 4'h9 : 4'h2;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                reti <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
    // Completion marks only the last clock of an instruction cycle
    assign cpu_in = {gie, phase == 2'h3, reti};
endmodule // irel_partner

// ===== bench/irel_top_tb.sv
// Self-checking bench for the interrupt request enable logic
`timescale 1ns/10ps
module irel_top_tb;
    import irel_pkg::*;
    typedef struct packed {
        logic       w;
        logic [5:0] idx;
        logic [3:0] wd;
        logic [3:0] ex;
    } irel_row_t;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           irq;
    logic           bt_p = 1'b0;
    logic           ser_p = 1'b0;
    logic           ser_en = 1'b0;
    logic [2:0]     raise = 3'h0;
    logic           gie = 1'b0;
    logic           slow = 1'b0;
    logic           prev_done = 1'b0;
    logic [2:0]     flags;
    logic [31:0]    rd;
    logic           err;
    irel_src_in_t   src_in;
    irel_cpu_in_t   cpu_in;
    irel_cpu_out_t  cpu_out;
    irel_src_t      vq[$];
    int             fail_count = 0;
    int             n_tests = 0;
    irel_row_t      rows[12] = '{
        {1'b0, IREL_IDX_ENABLE, 4'h0, 4'h0},
        {1'b0, IREL_IDX_SER_REQ, 4'h0, 4'h0},
        {1'b1, IREL_IDX_ENABLE, 4'hF, 4'hF},
        {1'b1, IREL_IDX_ENABLE, 4'h9, 4'h9},
        {1'b1, IREL_IDX_SER_REQ, 4'hF, 4'h1},
        {1'b1, IREL_IDX_SER_REQ, 4'h0, 4'h0},
        {1'b1, IREL_IDX_BT_REQ, 4'h3, 4'h1},
        {1'b1, IREL_IDX_BT_REQ, 4'h0, 4'h0},
        {1'b1, IREL_IDX_MASK, 4'h5, 4'h5},
        {1'b1, IREL_IDX_MASK, 4'h0, 4'h0},
        {1'b0, IREL_IDX_STATUS, 4'h0, 4'h0},
        {1'b0, IREL_IDX_SERVICE, 4'h0, 4'h7}
    };
    assign src_in = {bt_p, ser_p, flags, ser_en};
    // Half period of 5 ns gives 100 MHz
    always #5 pclk = ~pclk;
    irel_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_in(src_in), .cpu_in(cpu_in), .cpu_out(cpu_out), .irq(irq));
    irel_partner i_partner (.pclk(pclk), .presetn(presetn), .raise(raise), .gie(gie),
        .slow(slow), .cpu_out(cpu_out), .flags(flags), .cpu_in(cpu_in));
    // ==========================================================================
    // Record every accepted source; acceptance must follow a completed instruction
    always @(posedge pclk) begin
        if (cpu_out.prep === 1'b1) begin
            vq.push_back(cpu_out.vector);
            chk(32'(prev_done), 32'h1);
        end
        prev_done <= cpu_in.instr_done;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                stop_test();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // Event pulses: basic timer, serial, and raising of outside flags
    task automatic ev(input logic [4:0] v);
        @(posedge pclk);
        {bt_p, ser_p, raise} <= v;
        @(posedge pclk);
        {bt_p, ser_p, raise} <= 5'h00;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Wait until n acceptances are seen and the sequencer is out of service
    task automatic wait_prep(input int n);
        int k;
        k = 0;
        while (vq.size() < n || cpu_out.in_service !== 1'b0) begin
            k++;
            if (k > 300) begin
                fail_count++;
                stop_test();
            end
            @(posedge pclk);
        end
        idle(2);
    endtask
    initial begin
        idle(6);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].idx, 32'(rows[i].wd));
            rchk(rows[i].idx, 32'(rows[i].ex));
        end
        apb(1'b0, 6'h00, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        $display("register table done");
        // Basic timer request held while disabled, then serviced and cleared
        apb(1'b1, IREL_IDX_ENABLE, 32'h0);
        gie <= 1'b1;
        ev(5'h10);
        idle(12);
        rchk(IREL_IDX_BT_REQ, 32'h1);
        chk(32'(vq.size()), 32'h0);
        apb(1'b1, IREL_IDX_ENABLE, 32'h8);
        wait_prep(1);
        chk(32'(vq[0]), 32'h3);
        rchk(IREL_IDX_BT_REQ, 32'h0);
        $display("basic timer done");
        // Serial request pends until its enable arrives
        ev(5'h08);
        idle(8);
        rchk(IREL_IDX_SER_REQ, 32'h1);
        ser_en <= 1'b1;
        wait_prep(2);
        chk(32'(vq[1]), 32'h4);
        rchk(IREL_IDX_SER_REQ, 32'h0);
        $display("serial done");
        // Three outside requests: held by global and by local enables, then by priority
        apb(1'b1, IREL_IDX_ENABLE, 32'hF);
        gie <= 1'b0;
        ev(5'h07);
        idle(16);
        chk(32'(vq.size()), 32'h2);
        apb(1'b1, IREL_IDX_ENABLE, 32'h0);
        gie <= 1'b1;
        idle(16);
        chk(32'(vq.size()), 32'h2);
        slow <= 1'b1;
        apb(1'b1, IREL_IDX_ENABLE, 32'hF);
        wait_prep(5);
        for (int i = 0; i < 3; i++) chk(32'(vq[2 + i]), 32'(i));
        $display("priority done");
        // Interrupt line: raised, cleared by writing one, then masked
        apb(1'b1, IREL_IDX_STATUS, 32'h7);
        apb(1'b1, IREL_IDX_MASK, 32'h1);
        ev(5'h10);
        idle(3);
        chk(32'(irq), 32'h1);
        apb(1'b1, IREL_IDX_STATUS, 32'h1);
        idle(2);
        chk(32'(irq), 32'h0);
        apb(1'b1, IREL_IDX_MASK, 32'h0);
        ev(5'h10);
        idle(3);
        chk(32'(irq), 32'h0);
        wait_prep(7);
        $display("interrupt line done");
        // Reset in mid-run: enables and a forced serial request must be gone after it
        gie <= 1'b0;
        apb(1'b1, IREL_IDX_SER_REQ, 32'h1);
        presetn <= 1'b0;
        idle(2);
        chk(32'(cpu_out.vector), 32'h7);
        presetn <= 1'b1;
        rchk(IREL_IDX_ENABLE, 32'h0);
        rchk(IREL_IDX_SER_REQ, 32'h0);
        $display("reset done");
        stop_test();
    end
endmodule // irel_top_tb
